/* File: aat_defines.vh */
`ifndef AAT_DEFINES_VH
`define AAT_DEFINES_VH

// number of interrupt event sources
`define AAT_NUM_EVT 8
// least high time of the block-start input, in output master clock cycles
`define AAT_BLK_MIN_HIGH_CYC 3
// counter width for the block-start qualifier
`define AAT_BLK_CNT_W 2
// counter value at which the least high time is met
`define AAT_BLK_QUAL_CNT 2'h2
// transmit source select encodings
`define AAT_SRC_SERIAL 1'b0
`define AAT_SRC_AUX 1'b1
// user-data pin direction encodings
`define AAT_UDIR_INPUT 1'b0
`define AAT_UDIR_OUTPUT 1'b1
// block-start pin direction encodings
`define AAT_BDIR_INPUT 1'b0
`define AAT_BDIR_OUTPUT 1'b1
// reset values
`define AAT_STAT_RST 8'h00
`define AAT_UDIR_RST 1'b0

`endif

/* File: aat_aux_ctrl.v */
// Summary of operation
// RULE1 - in two-wire mode the third address pin gives control address bit 2
// RULE2 - accept pre-encoded biphase input as alternate transmit source
// RULE3 - each interrupt event source has its own mask bit
// RULE4 - readable status shows which events caused the interrupt
// RULE5 - configuration picks interrupt polarity and push-pull or open-drain drive
// RULE6 - interrupt drops only after status read and all status bits zero
// RULE7 - block-start output is high for first sub-frame of each block
// RULE8 - block-start input high three cycles restarts block at next sub-frame
// RULE9 - user pin as input supplies transmitted user bits
// RULE10 - user pin as output selects internal buffer and drives it out
// RULE11 - user pin direction resets to input
// RULE12 - hardware/software pin high enters standalone hardware mode
// RULE13 - hardware mode gives pins alternate roles and reduces configuration
// RULE14 - hardware mode routes serial audio input to transmitter
// RULE15 - falling edge on address-0/select pin switches to four-wire mode
// RULE16 - in hardware mode direction pin sets block-start pin direction
// RULE17 - block-start input synchronised before its high time is qualified
`timescale 1ns/1ps
`include "aat_defines.vh"

module aat_aux_ctrl (
  // clock and reset
  input wire core_clk_i,
  input wire rst_b_i,
  // mode pins
  input wire hw_sw_sel_pin_i,
  input wire addr0_or_select_pin_i,
  input wire ctrl_addr_bit2_pin_i,
  input wire block_start_dir_pin_i,
  // software configuration
  input wire aux_src_sel_i,
  input wire blk_dir_out_i,
  input wire user_pin_dir_bit_i,
  input wire [`AAT_NUM_EVT-1:0] int_mask_i,
  input wire int_pol_high_i,
  input wire int_open_drain_i,
  input wire int_stat_rd_i,
  // event sources
  input wire [`AAT_NUM_EVT-1:0] evt_i,
  // transmitter framing
  input wire sf_strobe_i,
  input wire cs_blk_begin_i,
  // audio sources
  input wire aux_biphase_input_i,
  input wire user_buf_bit_i,
  // pins
  input wire cs_block_start_pin_i,
  input wire user_pin_i,
  // mode status
  output reg hw_mode_o,
  output reg spi_mode_o,
  output reg ctrl_addr_bit2_o,
  // transmit source
  output reg tx_src_o,
  output reg aux_biphase_o,
  output reg user_bit_tx_o,
  // interrupt
  output reg [`AAT_NUM_EVT-1:0] int_stat_o,
  output reg int_pin_o,
  output reg int_pin_oe_o,
  // block start
  output reg cs_block_start_pin_o,
  output reg cs_block_start_pin_oe_o,
  output reg cs_blk_restart_o,
  // user pin
  output reg user_pin_o,
  output reg user_pin_oe_o
);

  reg strap_done_r;
  reg hw_mode_r;
  reg addr0_prev_r;
  reg spi_mode_r;
  reg [`AAT_NUM_EVT-1:0] stat_r;
  reg [`AAT_NUM_EVT-1:0] stat_nxt;
  reg int_act_r;
  reg int_act_nxt;
  reg rd_seen_r;
  reg rd_seen_nxt;
  reg blk_sync1_r;
  reg blk_sync2_r;
  reg [`AAT_BLK_CNT_W-1:0] blk_cnt_r;
  reg blk_pend_r;
  reg first_sf_r;
  reg user_dir_r;
  wire blk_dir_out;
  wire user_dir_out;
  wire blk_qual;
  wire int_level;

  // strap caught on first clock after reset release
  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      strap_done_r <= 1'b0;
      hw_mode_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      hw_mode_r <= hw_sw_sel_pin_i; // [RULE12]
    end
  end

  // control port mode select
  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      addr0_prev_r <= 1'b0;
      spi_mode_r <= 1'b0;
    end
    else
    begin
      addr0_prev_r <= addr0_or_select_pin_i;
      if (strap_done_r && !hw_mode_r && addr0_prev_r && !addr0_or_select_pin_i)
        spi_mode_r <= 1'b1; // [RULE15]
    end
  end

  // hardware mode overrides directions
  assign blk_dir_out = hw_mode_r ? block_start_dir_pin_i : blk_dir_out_i; // [RULE16] [RULE13]
  assign user_dir_out = hw_mode_r ? `AAT_UDIR_INPUT : user_dir_r; // [RULE13]

  // sticky status, set wins over read clear
  always @*
  begin
    stat_nxt = stat_r;
    rd_seen_nxt = rd_seen_r;
    int_act_nxt = int_act_r;
    if (int_stat_rd_i)
      stat_nxt = {`AAT_NUM_EVT{1'b0}};
    stat_nxt = stat_nxt | evt_i; // [RULE4]
    if (int_stat_rd_i && int_act_r)
      rd_seen_nxt = 1'b1;
    if (|(stat_r & int_mask_i))
      int_act_nxt = 1'b1; // [RULE3]
    else if (int_act_r && rd_seen_r && stat_r == `AAT_STAT_RST)
    begin
      int_act_nxt = 1'b0; // [RULE6]
      rd_seen_nxt = 1'b0;
    end
    if (hw_mode_r)
    begin
      int_act_nxt = 1'b0;
      rd_seen_nxt = 1'b0;
    end
  end

  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      stat_r <= `AAT_STAT_RST;
      int_act_r <= 1'b0;
      rd_seen_r <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      int_act_r <= int_act_nxt;
      rd_seen_r <= rd_seen_nxt;
    end
  end

  // asserted level follows polarity
  assign int_level = int_act_nxt ? int_pol_high_i : ~int_pol_high_i; // [RULE5]

  // user direction, input after reset
  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      user_dir_r <= `AAT_UDIR_RST; // [RULE11]
    else
      user_dir_r <= user_pin_dir_bit_i;
  end

  // block-start input synchroniser and width qualifier
  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      blk_sync1_r <= 1'b0;
      blk_sync2_r <= 1'b0;
    end
    else
    begin
      blk_sync1_r <= cs_block_start_pin_i; // [RULE17]
      blk_sync2_r <= blk_sync1_r;
    end
  end

  assign blk_qual = (blk_cnt_r == `AAT_BLK_QUAL_CNT) && blk_sync2_r;

  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      blk_cnt_r <= {`AAT_BLK_CNT_W{1'b0}};
      blk_pend_r <= 1'b0;
      cs_blk_restart_o <= 1'b0;
    end
    else
    begin
      cs_blk_restart_o <= 1'b0;
      if (blk_dir_out != `AAT_BDIR_INPUT || !blk_sync2_r)
        blk_cnt_r <= {`AAT_BLK_CNT_W{1'b0}};
      else if (blk_cnt_r != `AAT_BLK_QUAL_CNT)
        blk_cnt_r <= blk_cnt_r + 1'b1;
      if (blk_dir_out != `AAT_BDIR_INPUT)
        blk_pend_r <= 1'b0;
      else if (sf_strobe_i && (blk_pend_r || blk_qual))
      begin
        blk_pend_r <= 1'b0;
        cs_blk_restart_o <= 1'b1; // [RULE8]
      end
      else if (blk_qual)
        blk_pend_r <= 1'b1; // [RULE8]
    end
  end

  // first sub-frame of block tracker
  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      first_sf_r <= 1'b0;
    else if (sf_strobe_i)
      first_sf_r <= cs_blk_begin_i; // [RULE7]
  end

  // registered outputs
  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hw_mode_o <= 1'b0;
      spi_mode_o <= 1'b0;
      ctrl_addr_bit2_o <= 1'b0;
      tx_src_o <= `AAT_SRC_SERIAL;
      aux_biphase_o <= 1'b0;
      user_bit_tx_o <= 1'b0;
      int_stat_o <= `AAT_STAT_RST;
      int_pin_o <= 1'b0;
      int_pin_oe_o <= 1'b0;
      cs_block_start_pin_o <= 1'b0;
      cs_block_start_pin_oe_o <= 1'b0;
      user_pin_o <= 1'b0;
      user_pin_oe_o <= 1'b0;
    end
    else
    begin
      hw_mode_o <= hw_mode_r;
      spi_mode_o <= spi_mode_r;
      ctrl_addr_bit2_o <= (!spi_mode_r && !hw_mode_r) ? ctrl_addr_bit2_pin_i : 1'b0; // [RULE1]
      tx_src_o <= hw_mode_r ? `AAT_SRC_SERIAL : aux_src_sel_i; // [RULE14] [RULE2]
      aux_biphase_o <= aux_biphase_input_i; // [RULE2]
      user_bit_tx_o <= (user_dir_out == `AAT_UDIR_OUTPUT) ?
        user_buf_bit_i : user_pin_i; // [RULE9] [RULE10]
      int_stat_o <= stat_nxt;
      if (int_open_drain_i)
      begin
        int_pin_o <= 1'b0;
        int_pin_oe_o <= ~int_level; // [RULE5]
      end
      else
      begin
        int_pin_o <= int_level;
        int_pin_oe_o <= 1'b1;
      end
      cs_block_start_pin_oe_o <= (blk_dir_out == `AAT_BDIR_OUTPUT);
      cs_block_start_pin_o <= (blk_dir_out == `AAT_BDIR_OUTPUT) &&
        (sf_strobe_i ? cs_blk_begin_i : first_sf_r); // [RULE7]
      user_pin_oe_o <= (user_dir_out == `AAT_UDIR_OUTPUT); // [RULE10]
      user_pin_o <= (user_dir_out == `AAT_UDIR_OUTPUT) ? user_buf_bit_i : 1'b0;
    end
  end

endmodule // aat_aux_ctrl

/* File: aat_aux_ctrl_assertions.sv */
`timescale 1ns/1ps
module aat_aux_ctrl_chk (
  // watched ports
  input wire core_clk_i,
  input wire rst_b_i,
  input wire [7:0] evt_i,
  input wire int_stat_rd_i,
  input wire int_pol_high_i,
  input wire int_open_drain_i,
  input wire sf_strobe_i,
  input wire aux_biphase_input_i,
  input wire [7:0] int_stat_o,
  input wire int_pin_o,
  input wire cs_blk_restart_o,
  input wire aux_biphase_o,
  input wire hw_mode_o,
  input wire tx_src_o,
  input wire spi_mode_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_stat_set; evt_i[0] |=> int_stat_o[0]; endproperty
  a_stat_set: assert property (p_stat_set) else $error("status not set");
  property p_stat_clr; int_stat_rd_i && evt_i == 8'h00 |=> int_stat_o == 8'h00; endproperty
  a_stat_clr: assert property (p_stat_clr) else $error("status not cleared");
  // no read lately, so an active request must stay up
  property p_int_hold; int_pin_o && int_pol_high_i && !int_open_drain_i && !int_stat_rd_i
    && !$past(int_stat_rd_i) && !$past(int_stat_rd_i, 2) |=> int_pin_o; endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt dropped early");
  property p_od; int_open_drain_i && $past(int_open_drain_i) |-> !int_pin_o; endproperty
  a_od: assert property (p_od) else $error("open drain drives high");
  property p_restart; cs_blk_restart_o |-> $past(sf_strobe_i); endproperty
  a_restart: assert property (p_restart) else $error("restart off sub-frame");
  property p_aux; aux_biphase_o == $past(aux_biphase_input_i); endproperty
  a_aux: assert property (p_aux) else $error("aux path wrong");
  property p_hw_src; hw_mode_o && $past(hw_mode_o) |-> !tx_src_o; endproperty
  a_hw_src: assert property (p_hw_src) else $error("hw source wrong");
  property p_spi; spi_mode_o |=> spi_mode_o; endproperty
  a_spi: assert property (p_spi) else $error("four-wire mode lost");
endmodule // aat_aux_ctrl_chk

/* File: aat_host_model.sv */
`timescale 1ns/1ps
module aat_host_model (
  // control
  input wire core_clk_i,
  input wire [3:0] blk_len_i,
  input wire blk_go_i,
  input wire u_bit_i,
  // device pins
  input wire blk_o_i,
  input wire blk_oe_i,
  input wire u_o_i,
  input wire u_oe_i,
  output wire blk_pin_o,
  output wire u_pin_o
);
  logic [3:0] cnt_r = 4'h0;
  // hold block-start high for the asked cycles
  always @(posedge core_clk_i)
    cnt_r <= blk_go_i ? blk_len_i : cnt_r - {3'h0, cnt_r != 4'h0};
  assign blk_pin_o = blk_oe_i ? blk_o_i : (cnt_r != 4'h0);
  assign u_pin_o = u_oe_i ? u_o_i : u_bit_i;
endmodule // aat_host_model

/* File: aat_aux_ctrl_test.sv */
`timescale 1ns/1ps
module aat_aux_ctrl_test;
  logic core_clk_i = 1'b0, rst_b_i = 1'b0, hw_sw_sel_pin_i = 1'b0, addr0_or_select_pin_i = 1'b0;
  logic ctrl_addr_bit2_pin_i = 1'b0, block_start_dir_pin_i = 1'b0, aux_src_sel_i = 1'b0;
  logic blk_dir_out_i = 1'b0, user_pin_dir_bit_i = 1'b0, int_pol_high_i = 1'b1;
  logic int_open_drain_i = 1'b0, int_stat_rd_i = 1'b0, sf_strobe_i = 1'b0, cs_blk_begin_i = 1'b0;
  logic aux_biphase_input_i = 1'b0, user_buf_bit_i = 1'b0, blk_go = 1'b0, host_u = 1'b0, seen;
  logic [7:0] int_mask_i = 8'h01, evt_i = 8'h00;
  logic [3:0] blk_len = 4'h0;
  wire cs_block_start_pin_i, user_pin_i, hw_mode_o, spi_mode_o, ctrl_addr_bit2_o, tx_src_o;
  wire aux_biphase_o, user_bit_tx_o, int_pin_o, int_pin_oe_o, cs_block_start_pin_o;
  wire cs_block_start_pin_oe_o, cs_blk_restart_o, user_pin_o, user_pin_oe_o;
  wire [7:0] int_stat_o;
  int fails = 0, compares = 0;
  aat_aux_ctrl u_aat_aux_ctrl (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .hw_sw_sel_pin_i(hw_sw_sel_pin_i), .addr0_or_select_pin_i(addr0_or_select_pin_i),
    .ctrl_addr_bit2_pin_i(ctrl_addr_bit2_pin_i), .block_start_dir_pin_i(block_start_dir_pin_i),
    .aux_src_sel_i(aux_src_sel_i), .blk_dir_out_i(blk_dir_out_i),
    .user_pin_dir_bit_i(user_pin_dir_bit_i), .int_mask_i(int_mask_i),
    .int_pol_high_i(int_pol_high_i), .int_open_drain_i(int_open_drain_i),
    .int_stat_rd_i(int_stat_rd_i), .evt_i(evt_i), .sf_strobe_i(sf_strobe_i),
    .cs_blk_begin_i(cs_blk_begin_i), .aux_biphase_input_i(aux_biphase_input_i),
    .user_buf_bit_i(user_buf_bit_i), .cs_block_start_pin_i(cs_block_start_pin_i),
    .user_pin_i(user_pin_i), .hw_mode_o(hw_mode_o), .spi_mode_o(spi_mode_o),
    .ctrl_addr_bit2_o(ctrl_addr_bit2_o), .tx_src_o(tx_src_o), .aux_biphase_o(aux_biphase_o),
    .user_bit_tx_o(user_bit_tx_o), .int_stat_o(int_stat_o), .int_pin_o(int_pin_o),
    .int_pin_oe_o(int_pin_oe_o), .cs_block_start_pin_o(cs_block_start_pin_o),
    .cs_block_start_pin_oe_o(cs_block_start_pin_oe_o), .cs_blk_restart_o(cs_blk_restart_o),
    .user_pin_o(user_pin_o), .user_pin_oe_o(user_pin_oe_o));
  aat_host_model u_aat_host_model (.core_clk_i(core_clk_i), .blk_len_i(blk_len),
    .blk_go_i(blk_go), .u_bit_i(host_u), .blk_o_i(cs_block_start_pin_o),
    .blk_oe_i(cs_block_start_pin_oe_o), .u_o_i(user_pin_o), .u_oe_i(user_pin_oe_o),
    .blk_pin_o(cs_block_start_pin_i), .u_pin_o(user_pin_i));
  initial forever #2 core_clk_i = ~core_clk_i;
  task tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task rst(input logic hw);
    rst_b_i <= 1'b0;
    hw_sw_sel_pin_i <= hw;
    tick(20);
    rst_b_i <= 1'b1;
    tick(2);
  endtask
  // host pulse of n cycles, then one sub-frame strobe
  task blk_in(input logic [3:0] n, input logic e);
    blk_len <= n;
    blk_go <= 1'b1;
    tick(1);
    blk_go <= 1'b0;
    tick(10);
    sf_strobe_i <= 1'b1;
    tick(1);
    sf_strobe_i <= 1'b0;
    seen = 1'b0;
    repeat (3)
    begin
      tick(1);
      seen |= cs_blk_restart_o;
    end
    chk("restart", {7'h0, e}, {7'h0, seen});
  endtask
  task evt(input logic [7:0] v);
    evt_i <= v;
    tick(1);
    evt_i <= 8'h00;
    tick(3);
  endtask
  initial
  begin
    // direction bit high across reset: first output must still show input
    user_pin_dir_bit_i <= 1'b1;
    rst(1'b0);
    chk("udir", 8'h00, {7'h0, user_pin_oe_o});
    user_pin_dir_bit_i <= 1'b0;
    evt(8'h01);
    chk("stat", 8'h01, int_stat_o);
    chk("int", 8'h01, {7'h0, int_pin_o});
    int_stat_rd_i <= 1'b1;
    tick(1);
    int_stat_rd_i <= 1'b0;
    tick(3);
    chk("int", 8'h00, {7'h0, int_pin_o});
    evt(8'h02);
    chk("mask", 8'h02, {int_stat_o[7:1], int_pin_o});
    int_pol_high_i <= 1'b0;
    tick(2);
    chk("pol", 8'h03, {6'h0, int_pin_oe_o, int_pin_o});
    int_open_drain_i <= 1'b1;
    tick(2);
    chk("od", 8'h00, {6'h0, int_pin_oe_o, int_pin_o});
    evt(8'h01);
    chk("odact", 8'h02, {6'h0, int_pin_oe_o, int_pin_o});
    int_stat_rd_i <= 1'b1;
    tick(1);
    int_stat_rd_i <= 1'b0;
    tick(3);
    chk("odrel", 8'h00, {6'h0, int_pin_oe_o, int_pin_o});
    blk_in(4'h2, 1'b0);
    blk_in(4'h3, 1'b1);
    blk_dir_out_i <= 1'b1;
    sf_strobe_i <= 1'b1;
    cs_blk_begin_i <= 1'b1;
    tick(1);
    sf_strobe_i <= 1'b0;
    cs_blk_begin_i <= 1'b0;
    tick(2);
    chk("bout", 8'h03, {6'h0, cs_block_start_pin_oe_o, cs_block_start_pin_o});
    blk_in(4'h0, 1'b0);
    chk("bout", 8'h00, {7'h0, cs_block_start_pin_o});
    host_u <= 1'b1;
    tick(3);
    chk("utx", 8'h01, {7'h0, user_bit_tx_o});
    user_pin_dir_bit_i <= 1'b1;
    user_buf_bit_i <= 1'b1;
    host_u <= 1'b0;
    ctrl_addr_bit2_pin_i <= 1'b1;
    addr0_or_select_pin_i <= 1'b1;
    tick(4);
    chk("uout", 8'h07, {5'h0, user_bit_tx_o, user_pin_oe_o, user_pin_o});
    chk("addr2", 8'h01, {7'h0, ctrl_addr_bit2_o});
    addr0_or_select_pin_i <= 1'b0;
    aux_src_sel_i <= 1'b1;
    aux_biphase_input_i <= 1'b1;
    tick(3);
    chk("spi", 8'h02, {6'h0, spi_mode_o, ctrl_addr_bit2_o});
    chk("aux", 8'h03, {6'h0, tx_src_o, aux_biphase_o});
    aux_biphase_input_i <= 1'b0;
    block_start_dir_pin_i <= 1'b1;
    rst(1'b1);
    tick(1);
    chk("hw", 8'h0a,
      {4'h0, hw_mode_o, tx_src_o, cs_block_start_pin_oe_o, user_pin_oe_o});
    evt(8'h01);
    chk("hwint", 8'h00, {6'h0, int_pin_oe_o, int_pin_o});
    finish_test;
  end
endmodule // aat_aux_ctrl_test
bind aat_aux_ctrl aat_aux_ctrl_chk u_aat_aux_ctrl_chk (.core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i), .evt_i(evt_i), .int_stat_rd_i(int_stat_rd_i),
  .int_pol_high_i(int_pol_high_i), .int_open_drain_i(int_open_drain_i),
  .sf_strobe_i(sf_strobe_i), .aux_biphase_input_i(aux_biphase_input_i),
  .int_stat_o(int_stat_o), .int_pin_o(int_pin_o), .cs_blk_restart_o(cs_blk_restart_o),
  .aux_biphase_o(aux_biphase_o), .hw_mode_o(hw_mode_o), .tx_src_o(tx_src_o),
  .spi_mode_o(spi_mode_o));
